// file: hdl/srb_bridge.sv
// Purpose: legacy segment-register instructions onto 16 fixed lookaside
//          entries of the segment_lookaside_buffer
// Assumes: one request per cycle, answered one cycle later
// Notes: reload port models segment-table hardware refill of an entry
//
// What this block does
// (RULE1) all four instructions enabled together only
// (RULE2) unsupported bridge raises illegal-instruction exception
// (RULE3) needs segment-table enable bit implemented
// (RULE4) sixteen entries act as segment registers
// (RULE5) write takes 32 bits, read returns 64
// (RULE6) indirect read indexes by index_gpr bits 32-35
// (RULE7) read packs virtual_segment_id, keys, no-execute fields
// (RULE8) read result bits 0-6 are zero
// (RULE9) entry not bridge-written reads undefined
// (RULE10) enable set after write makes read undefined
// (RULE11) writes update replacement history like reloads
// (RULE12) supervisor state only
// (RULE13) page table formats left untouched
// (RULE14) boot software clears mode, enable, entries
// (RULE15) software changes only low machine-state half
// (RULE16) software keeps segment-table enable at zero
// (RULE17) software keeps segments 0-15 mapped
// (RULE18) software never issues lookaside invalidates
// (RULE19) software keeps addresses in 32-bit range
// (RULE20) software keeps entry segment ids unique
// (RULE21) write sets valid, keys, no-execute, low virtual_segment_id
// (RULE22) indirect write indexes by index_gpr bits 32-35
// (RULE23) direct forms use four-bit instruction field
`default_nettype none

module srb_bridge #(
	parameter bit BRIDGE_SUPPORTED = 1'b1,
	parameter bit STE_ENABLE_IMPL = 1'b1
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// instruction request
	input wire srb_pkg::srb_req_t req,
	// segment_table_base_register enable bit
	input wire logic segment_table_enable,
	// hardware refill from the segment table
	input wire srb_pkg::srb_reload_t reload,
	// answers
	output srb_pkg::srb_resp_t resp,
	output logic illegal_exc,
	output logic priv_exc,
	output logic [srb_pkg::IDX_W-1:0] replace_victim
);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic is_write(input srb_pkg::srb_op_t op);
		return op == srb_pkg::SRB_WRITE_DIRECT ||
			op == srb_pkg::SRB_WRITE_INDIRECT;
	endfunction : is_write

	function automatic logic [srb_pkg::IDX_W-1:0] pick_index(
		input srb_pkg::srb_req_t r);
		logic indirect;
		indirect = r.op == srb_pkg::SRB_WRITE_INDIRECT ||
			r.op == srb_pkg::SRB_READ_INDIRECT;
		if (indirect) begin
			return r.index_gpr[srb_pkg::IDX_HI:srb_pkg::IDX_LO]; // [RULE6] [RULE22]
		end
		return r.segment_index_field; // [RULE23]
	endfunction : pick_index

	logic accept;
	logic bridge_ok;
	logic legal;
	logic wr;
	logic rd;
	logic [srb_pkg::IDX_W-1:0] sel_idx;
	srb_pkg::srb_entry_t sel_entry;

	// one switch governs all four forms, so no subset can exist
	assign bridge_ok = BRIDGE_SUPPORTED && STE_ENABLE_IMPL; // [RULE1] [RULE3]
	assign accept = ce && req.valid;
	assign legal = accept && bridge_ok && req.supervisor; // [RULE12]
	assign wr = legal && is_write(req.op);
	assign rd = legal && !is_write(req.op);
	assign sel_idx = pick_index(req);

	// ----------------------------------------------------------------
	// entries
	// ----------------------------------------------------------------
	// only segment descriptors live here; page table formats never pass
	srb_pkg::srb_entry_t entries [srb_pkg::NUM_ENTRIES]; // [RULE4] [RULE13]

	assign sel_entry = entries[sel_idx];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < srb_pkg::NUM_ENTRIES; i++) begin
				entries[i] <= '0;
			end
		end else if (ce) begin
			for (int i = 0; i < srb_pkg::NUM_ENTRIES; i++) begin
				if (wr && sel_idx == i[srb_pkg::IDX_W-1:0]) begin
					// only source bits 32-63 are used
					entries[i].valid <= 1'b1; // [RULE21] [RULE5]
					entries[i].by_bridge <= 1'b1;
					entries[i].stale <= segment_table_enable;
					entries[i].keys <=
						req.source_gpr[srb_pkg::KEY_HI:srb_pkg::KEY_LO]; // [RULE21]
					entries[i].no_exec <=
						req.source_gpr[srb_pkg::NX_HI:srb_pkg::NX_LO]; // [RULE21]
					entries[i].virtual_segment_id <= {
						{srb_pkg::VIRTUAL_SEGMENT_ID_HI_W{1'b0}},
						req.source_gpr[srb_pkg::VLO_HI:srb_pkg::VLO_LO]}; // [RULE21]
				end else if (reload.valid &&
					reload.index == i[srb_pkg::IDX_W-1:0]) begin
					entries[i].valid <= 1'b1;
					entries[i].by_bridge <= 1'b0;
					entries[i].stale <= 1'b0;
					entries[i].keys <= reload.keys;
					entries[i].no_exec <= reload.no_exec;
					entries[i].virtual_segment_id <= reload.virtual_segment_id;
				end else if (segment_table_enable) begin
					// hardware may have refilled it meanwhile
					entries[i].stale <= 1'b1; // [RULE10]
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// read answer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			resp <= '0;
		end else if (ce) begin
			resp.done <= rd;
			resp.defined <= rd && sel_entry.valid &&
				sel_entry.by_bridge && !sel_entry.stale; // [RULE9] [RULE10]
			if (rd) begin
				resp.data <= '0; // [RULE8]
				resp.data[srb_pkg::VHI_HI:srb_pkg::VHI_LO] <=
					sel_entry.virtual_segment_id[
						srb_pkg::VIRTUAL_SEGMENT_ID_W-1:srb_pkg::VIRTUAL_SEGMENT_ID_LO_W]; // [RULE7]
				resp.data[srb_pkg::KEY_HI:srb_pkg::KEY_LO] <= sel_entry.keys; // [RULE7]
				resp.data[srb_pkg::NX_HI:srb_pkg::NX_LO] <= sel_entry.no_exec; // [RULE7]
				resp.data[srb_pkg::VLO_HI:srb_pkg::VLO_LO] <=
					sel_entry.virtual_segment_id[srb_pkg::VIRTUAL_SEGMENT_ID_LO_W-1:0]; // [RULE7]
			end
		end
	end

	// ----------------------------------------------------------------
	// exceptions
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			illegal_exc <= 1'b0;
			priv_exc <= 1'b0;
		end else if (ce) begin
			illegal_exc <= req.valid && !bridge_ok; // [RULE2] [RULE3]
			priv_exc <= req.valid && bridge_ok && !req.supervisor; // [RULE12]
		end
	end

	// ----------------------------------------------------------------
	// replacement history
	// ----------------------------------------------------------------
	// clock-style pseudo-lru: cheap, and exact lru is not promised
	logic [srb_pkg::NUM_ENTRIES-1:0] ref_bits;
	logic [srb_pkg::NUM_ENTRIES-1:0] touch_vec;
	logic touch_en;

	assign touch_en = wr || reload.valid; // [RULE11]

	always_comb begin
		touch_vec = '0;
		// a write and a reload in one cycle both count as touches
		if (wr) begin
			touch_vec[sel_idx] = 1'b1; // [RULE11]
		end
		if (reload.valid) begin
			touch_vec[reload.index] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ref_bits <= '0;
		end else if (ce && touch_en) begin
			if ((ref_bits | touch_vec) == '1) begin
				ref_bits <= touch_vec;
			end else begin
				ref_bits <= ref_bits | touch_vec;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			replace_victim <= '0;
		end else if (ce) begin
			replace_victim <= '0;
			for (int i = srb_pkg::NUM_ENTRIES - 1; i >= 0; i--) begin
				if (!ref_bits[i]) begin
					replace_victim <= i[srb_pkg::IDX_W-1:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	logic [srb_pkg::IDX_W-1:0] last_sel;
	logic [srb_pkg::GPR_W-1:0] last_src;

	always_ff @(posedge clk) begin
		if (ce) begin
			last_sel <= sel_idx;
			last_src <= req.source_gpr;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_unsupported;
		ce && req.valid && !bridge_ok;
	endsequence

	sequence s_user_try;
		ce && req.valid && bridge_ok && !req.supervisor;
	endsequence

	property p_illegal;
		s_unsupported |=> illegal_exc && !resp.done;
	endproperty
	a_illegal: assert property (p_illegal) // [RULE2]
		else $error("unsupported bridge op gave no illegal exception");

	property p_priv;
		s_user_try |=> priv_exc && !resp.done && !illegal_exc;
	endproperty
	a_priv: assert property (p_priv) // [RULE12]
		else $error("problem-state bridge op not refused");

	property p_zero;
		resp.done |-> resp.data[srb_pkg::ZERO_HI:srb_pkg::ZERO_LO] == '0;
	endproperty
	a_zero: assert property (p_zero) // [RULE8]
		else $error("read result top seven bits not zero");

	property p_fill;
		wr |=> entries[last_sel].valid && entries[last_sel].by_bridge &&
			entries[last_sel].keys == last_src[srb_pkg::KEY_HI:srb_pkg::KEY_LO]
			&& entries[last_sel].no_exec ==
			last_src[srb_pkg::NX_HI:srb_pkg::NX_LO];
	endproperty
	a_fill: assert property (p_fill) // [RULE21]
		else $error("write did not fill entry fields");

	property p_width;
		wr |=> entries[last_sel].virtual_segment_id ==
			{{srb_pkg::VIRTUAL_SEGMENT_ID_HI_W{1'b0}},
			last_src[srb_pkg::VLO_HI:srb_pkg::VLO_LO]};
	endproperty
	a_width: assert property (p_width) // [RULE5]
		else $error("write took bits outside the low word");

	property p_indirect;
		legal && (req.op == srb_pkg::SRB_READ_INDIRECT ||
			req.op == srb_pkg::SRB_WRITE_INDIRECT) |->
			sel_idx == req.index_gpr[srb_pkg::IDX_HI:srb_pkg::IDX_LO];
	endproperty
	a_indirect: assert property (p_indirect) // [RULE6]
		else $error("indirect form used wrong index bits");

	property p_rw_loop;
		(wr && !segment_table_enable) ##1
			(rd && sel_idx == last_sel && !segment_table_enable) |=>
			resp.defined && resp.data[srb_pkg::VLO_HI:srb_pkg::VLO_LO] ==
			$past(last_src[srb_pkg::VLO_HI:srb_pkg::VLO_LO]);
	endproperty
	a_rw_loop: assert property (p_rw_loop) // [RULE7]
		else $error("read back of fresh write mismatched");

	property p_undef;
		rd && (!sel_entry.by_bridge || sel_entry.stale) |=> !resp.defined;
	endproperty
	a_undef: assert property (p_undef) // [RULE9]
		else $error("unwritten or stale entry read as defined");

	property p_history;
		ce && wr |=> ref_bits[last_sel];
	endproperty
	a_history: assert property (p_history) // [RULE11]
		else $error("write did not update replacement history");

endmodule : srb_bridge

`default_nettype wire

// file: hdl/srb_pkg.sv
// Purpose: shared constants and carriers for the segment register bridge
// Assumes: 64-bit registers numbered [63:0]; architectural bit k is [63-k]
// Notes: positions below are vector indices, not architectural numbers
`default_nettype none

package srb_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_ENTRIES = 16;
	localparam int IDX_W = 4;
	localparam int GPR_W = 64;
	localparam int VIRTUAL_SEGMENT_ID_W = 52;
	localparam int VIRTUAL_SEGMENT_ID_HI_W = 25;
	localparam int VIRTUAL_SEGMENT_ID_LO_W = 27;

	// ----------------------------------------------------------------
	// gpr field positions
	// ----------------------------------------------------------------
	// index_gpr bits 32-35
	localparam int IDX_HI = 31;
	localparam int IDX_LO = 28;
	// supervisor_key / problem_key, bits 33-34
	localparam int KEY_HI = 30;
	localparam int KEY_LO = 29;
	// no-execute pair, bits 35-36
	localparam int NX_HI = 28;
	localparam int NX_LO = 27;
	// low virtual_segment_id, bits 37-63
	localparam int VLO_HI = 26;
	localparam int VLO_LO = 0;
	// high virtual_segment_id in a read result, bits 7-31
	localparam int VHI_HI = 56;
	localparam int VHI_LO = 32;
	// forced-zero field of a read result, bits 0-6
	localparam int ZERO_HI = 63;
	localparam int ZERO_LO = 57;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRB_WRITE_DIRECT,
		SRB_WRITE_INDIRECT,
		SRB_READ_DIRECT,
		SRB_READ_INDIRECT
	} srb_op_t;

	typedef struct packed {
		logic valid;
		srb_op_t op;
		logic [IDX_W-1:0] segment_index_field;
		logic [GPR_W-1:0] index_gpr;
		logic [GPR_W-1:0] source_gpr;
		logic supervisor;
	} srb_req_t;

	typedef struct packed {
		logic valid;
		logic by_bridge;
		logic stale;
		logic [1:0] keys;
		logic [1:0] no_exec;
		logic [VIRTUAL_SEGMENT_ID_W-1:0] virtual_segment_id;
	} srb_entry_t;

	typedef struct packed {
		logic valid;
		logic [IDX_W-1:0] index;
		logic [1:0] keys;
		logic [1:0] no_exec;
		logic [VIRTUAL_SEGMENT_ID_W-1:0] virtual_segment_id;
	} srb_reload_t;

	typedef struct packed {
		logic done;
		logic defined;
		logic [GPR_W-1:0] data;
	} srb_resp_t;

endpackage : srb_pkg

`default_nettype wire

// file: dv/test_srb_bridge.sv
// Purpose: self-checking bench for the segment register bridge
// Assumes: answers registered on the taking edge itself; core clock 10 MHz
// Notes: extra instances lack bridge support or the enable bit
`default_nettype none

module test_srb_bridge;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic seg_tbl_en = 1'b0;
	srb_pkg::srb_req_t req = '0;
	srb_pkg::srb_reload_t reload = '0;
	srb_pkg::srb_resp_t resp, resp_ns, g_resp;
	logic ill, priv, ill_ns, priv_ns, g_ill, g_priv, g_ill_ns, ill_ni;
	logic [3:0] victim, victim_ns;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;

	srb_bridge srb_bridge_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
		.req(req), .segment_table_enable(seg_tbl_en), .reload(reload),
		.resp(resp), .illegal_exc(ill), .priv_exc(priv),
		.replace_victim(victim));

	srb_bridge #(.BRIDGE_SUPPORTED(1'b0)) srb_bridge_ns_inst (.clk(clk),
		.rst_n(rst_n), .ce(ce), .req(req), .segment_table_enable(seg_tbl_en),
		.reload(reload), .resp(resp_ns), .illegal_exc(ill_ns),
		.priv_exc(priv_ns), .replace_victim(victim_ns));

	srb_bridge #(.STE_ENABLE_IMPL(1'b0)) srb_bridge_ni_inst (.clk(clk),
		.rst_n(rst_n), .ce(ce), .req(req), .segment_table_enable(seg_tbl_en),
		.reload(reload), .resp(), .illegal_exc(ill_ni), .priv_exc(),
		.replace_victim());

	always #50 clk = ~clk;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic print_verdict();
		if (err_total == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict

	// hang guard: no scenario needs anywhere near this many cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic chk(input string what, input logic [63:0] got,
		input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// upper word and bit 31 are junk the bridge must drop
	function automatic logic [63:0] sv(input int i);
		return {32'hDEAD_BEEF, 1'b1, 4'(i), 27'h5A5_A5A5 ^ 27'(i)};
	endfunction : sv

	// the unused selector points elsewhere, so a wrong pick shows
	function automatic srb_pkg::srb_req_t mk(input srb_pkg::srb_op_t op,
		input logic [3:0] idx, input logic [63:0] src, input logic sup);
		srb_pkg::srb_req_t r;
		logic ind;
		ind = (op == srb_pkg::SRB_WRITE_INDIRECT) ||
			(op == srb_pkg::SRB_READ_INDIRECT);
		r.valid = 1'b1;
		r.op = op;
		r.segment_index_field = ind ? ~idx : idx;
		r.index_gpr = {32'hFFFF_FFFF, ind ? idx : ~idx, 28'hFFF_FFFF};
		r.source_gpr = src;
		r.supervisor = sup;
		return r;
	endfunction : mk

	task automatic do_op(input srb_pkg::srb_req_t r);
		@(posedge clk);
		req <= r;
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
		g_resp = resp;
		g_ill = ill;
		g_priv = priv;
		g_ill_ns = ill_ns;
	endtask : do_op

	task automatic rd_chk(input logic [3:0] idx, input logic ind,
		input logic def, input logic [63:0] src);
		do_op(mk(ind ? srb_pkg::SRB_READ_INDIRECT : srb_pkg::SRB_READ_DIRECT,
			idx, 64'h0, 1'b1));
		chk("done", 64'(g_resp.done), 64'h1);
		chk("defined", 64'(g_resp.defined), 64'(def));
		if (def) begin
			chk("data", g_resp.data, {33'h0, src[30:0]});
		end
	endtask : rd_chk

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk("reset resp", g_resp.data, 64'h0);
		chk("reset victim", 64'(victim), 64'h0);
		rd_chk(4'h5, 1'b0, 1'b0, 64'h0);
	endtask : t_reset

	task automatic t_victim();
		do_op(mk(srb_pkg::SRB_WRITE_DIRECT, 4'h0, sv(0), 1'b1));
		repeat (2) @(posedge clk);
		#1;
		chk("victim after write", 64'(victim), 64'h1);
		@(posedge clk);
		reload <= '{1'b1, 4'h1, 2'h0, 2'h0, 52'h1};
		@(posedge clk);
		reload.valid <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("victim after reload", 64'(victim), 64'h2);
		rd_chk(4'h1, 1'b1, 1'b0, 64'h0);
	endtask : t_victim

	task automatic t_all_entries();
		for (int i = 0; i < 16; i++) begin
			do_op(mk(i[0] ? srb_pkg::SRB_WRITE_INDIRECT :
				srb_pkg::SRB_WRITE_DIRECT, 4'(i), sv(i), 1'b1));
		end
		repeat (2) @(posedge clk);
		#1;
		chk("victim wrap", 64'(victim), 64'h0);
		for (int i = 0; i < 16; i++) begin
			rd_chk(4'(i), ~i[0], 1'b1, sv(i));
		end
	endtask : t_all_entries

	task automatic t_back_to_back();
		logic [63:0] s;
		s = sv(9);
		@(posedge clk);
		req <= mk(srb_pkg::SRB_WRITE_INDIRECT, 4'h7, s, 1'b1);
		@(posedge clk);
		req <= mk(srb_pkg::SRB_READ_INDIRECT, 4'h7, 64'h0, 1'b1);
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
		chk("b2b done", 64'(resp.done), 64'h1);
		chk("b2b data", resp.data, {33'h0, s[30:0]});
	endtask : t_back_to_back

	task automatic t_priv();
		do_op(mk(srb_pkg::SRB_WRITE_DIRECT, 4'h4, sv(3), 1'b0));
		chk("priv write", 64'(g_priv), 64'h1);
		rd_chk(4'h4, 1'b0, 1'b1, sv(4));
		do_op(mk(srb_pkg::SRB_READ_DIRECT, 4'h4, 64'h0, 1'b0));
		chk("priv read", 64'(g_priv), 64'h1);
		chk("priv no done", 64'(g_resp.done), 64'h0);
	endtask : t_priv

	// a request while the enable is low must leave every state alone
	task automatic t_freeze();
		@(posedge clk);
		ce <= 1'b0;
		req <= mk(srb_pkg::SRB_WRITE_DIRECT, 4'h3, sv(12), 1'b1);
		@(posedge clk);
		req.valid <= 1'b0;
		ce <= 1'b1;
		#1;
		chk("freeze no illegal", 64'(ill_ns), 64'h0);
		rd_chk(4'h3, 1'b0, 1'b1, sv(3));
	endtask : t_freeze

	task automatic t_stale();
		@(posedge clk);
		seg_tbl_en <= 1'b1;
		@(posedge clk);
		seg_tbl_en <= 1'b0;
		rd_chk(4'h2, 1'b0, 1'b0, 64'h0);
		do_op(mk(srb_pkg::SRB_WRITE_DIRECT, 4'h2, sv(2), 1'b1));
		rd_chk(4'h2, 1'b1, 1'b1, sv(2));
	endtask : t_stale

	task automatic t_unsupported();
		for (int k = 0; k < 4; k++) begin
			do_op(mk(srb_pkg::srb_op_t'(k), 4'h6, sv(6), 1'b1));
			chk("illegal off", 64'(g_ill_ns), 64'h1);
			chk("illegal on", 64'(g_ill), 64'h0);
			chk("illegal no enable bit", 64'(ill_ni), 64'h1);
			chk("ns no done", 64'(resp_ns.done), 64'h0);
			chk("ns no priv", 64'(priv_ns), 64'h0);
		end
	endtask : t_unsupported

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		g_resp = resp;
		t_reset();
		t_victim();
		t_all_entries();
		t_back_to_back();
		t_priv();
		t_freeze();
		t_stale();
		t_unsupported();
		print_verdict();
	end

endmodule : test_srb_bridge

`default_nettype wire
